// ### external_program_memory_port.sv
// External program memory port: word transfers to off-chip flash, ROM or RAM
// Functional notes
// R1 - 16-bit two-way data bus carries whole words to and from memory
// R2 - Word address driven on 21 output-only lines
// R3 - Write strobe low only during write cycles
// R4 - Output enable low during read cycles
// R5 - Chip select low for every transfer, high otherwise
// R6 - Memory reset follows hard reset, lagging about two clocks
// R7 - Memory reset moves only during boot, then static
// R8 - Addresses up to 32 Mbit of 16-bit words
// R9 - Attached memory holds at least 256k words
// R10 - Attached flash works in 16-bit word mode
// R11 - Attached flash obeys a supported program and erase command set
// R12 - Attached flash allows clearing bits of one word in two programs
// R13 - Attached flash has bounded program and erase times
// R14 - Attached flash is bottom boot or uniform sectors
// R15 - Attached flash has independent sectors at the listed low boundaries
// R16 - Wait states are configurable, two recommended
// R17 - Works with read-only masked memory in place of flash
// R18 - Optional external RAM may share the port
// R19 - DSP fetches run through a 64-entry instruction cache
// R20 - Never write and read strobes together; drive data only when writing
`timescale 1ns/1ns
module external_program_memory_port import epm_pkg::*; #(
    parameter int ADDR_W = EPM_ADDR_W,
    parameter int DATA_W = EPM_DATA_W,
    parameter int CACHE_DEPTH = EPM_CACHE_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    // Configuration
    input wire logic [EPM_WAIT_W-1:0] wait_states,
    input wire logic write_lock,
    // Processor request port
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_fetch,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    // Memory pins
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_data_in,
    output logic [DATA_W-1:0] mem_data_out,
    output logic mem_data_oe,
    output logic mem_we_n,
    output logic mem_oe_n,
    output logic mem_cs_n,
    output logic memory_reset_n
);
    localparam int IDX_W = $clog2(CACHE_DEPTH);
    localparam int TAG_W = ADDR_W - IDX_W;

    epm_state_t state_q;
    logic [EPM_WAIT_W-1:0] wait_q;
    logic wr_q;
    logic fetch_q;
    logic [DATA_W-1:0] cache_data [CACHE_DEPTH];
    logic [TAG_W-1:0] cache_tag [CACHE_DEPTH];
    logic [CACHE_DEPTH-1:0] cache_vld_q;
    logic hit;
    logic take;

    function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
        return a[IDX_W-1:0];
    endfunction

    function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:IDX_W];
    endfunction

    epm_reset_lag u_reset_lag (
        .clk(clk),
        .rstn(rstn),
        .memory_reset_n(memory_reset_n)
    );

    // Fetch hits answer from the cache; only mem_addr and mem_data_out latch at the pins
    assign hit = req_fetch && !req_write && cache_vld_q[idx_of(req_addr)]
        && cache_tag[idx_of(req_addr)] == tag_of(req_addr); // [R19]
    // Hold requests while flash is still in reset
    assign req_ready = clk_en && memory_reset_n && state_q == EPM_IDLE;
    assign take = req_valid && req_ready;

    // Transfer sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= EPM_IDLE;
            wait_q <= '0;
            wr_q <= 1'b0;
            fetch_q <= 1'b0;
        end else if (clk_en) begin
            case (state_q)
                EPM_IDLE: begin
                    // Masked ROM: a locked port starts no memory cycle for a write
                    if (take && !hit && !(req_write && write_lock)) begin // [R17]
                        state_q <= EPM_SETUP;
                        wr_q <= req_write;
                        fetch_q <= req_fetch && !req_write;
                    end
                end
                EPM_SETUP: begin
                    state_q <= EPM_STROBE;
                    wait_q <= wait_states; // [R16]
                end
                EPM_STROBE: begin
                    if (wait_q == '0) begin
                        state_q <= EPM_HOLD;
                    end else begin
                        wait_q <= wait_q - 1'b1; // [R16]
                    end
                end
                EPM_HOLD: state_q <= EPM_IDLE;
                default: state_q <= EPM_IDLE;
            endcase
        end
    end

    // Address and write data latched at acceptance
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_addr <= '0;
            mem_data_out <= '0;
        end else if (clk_en && take) begin
            mem_addr <= req_addr; // [R2] [R8] [R18]
            mem_data_out <= req_wdata; // [R1]
        end
    end

    // Strobes decoded from state; data driven only in a write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_cs_n <= 1'b1;
            mem_we_n <= 1'b1;
            mem_oe_n <= 1'b1;
            mem_data_oe <= 1'b0;
        end else if (clk_en) begin
            mem_cs_n <= !((state_q == EPM_IDLE && take && !hit
                && !(req_write && write_lock))
                || state_q == EPM_SETUP
                || (state_q == EPM_STROBE)); // [R5]
            mem_we_n <= !(wr_q && (state_q == EPM_SETUP
                || (state_q == EPM_STROBE && wait_q != '0))); // [R3] [R20]
            mem_oe_n <= !(!wr_q && (state_q == EPM_SETUP
                || (state_q == EPM_STROBE && wait_q != '0))); // [R4] [R20]
            mem_data_oe <= wr_q && (state_q == EPM_SETUP
                || state_q == EPM_STROBE); // [R1] [R20]
        end
    end

    // Read answer and cache fill
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            cache_vld_q <= '0;
        end else if (clk_en) begin
            rsp_valid <= 1'b0;
            if (take && hit) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= cache_data[idx_of(req_addr)]; // [R19]
            end else if (state_q == EPM_STROBE && wait_q == '0 && !wr_q) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= mem_data_in; // [R1]
                if (fetch_q) begin
                    cache_vld_q[idx_of(mem_addr)] <= 1'b1; // [R19]
                end
            end else if (take && req_write) begin
                // Writes may change code, so drop the stale line
                cache_vld_q[idx_of(req_addr)] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (clk_en && state_q == EPM_STROBE && wait_q == '0 && !wr_q && fetch_q) begin
            cache_data[idx_of(mem_addr)] <= mem_data_in;
            cache_tag[idx_of(mem_addr)] <= tag_of(mem_addr);
        end
    end

    a_strobe_excl: assert property (@(posedge clk) disable iff (!rstn)
        !(!mem_we_n && !mem_oe_n)) // [R20]
        else $error("write and read strobes together");
    a_drive_write: assert property (@(posedge clk) disable iff (!rstn)
        mem_data_oe |-> !mem_cs_n && mem_oe_n) // [R20]
        else $error("data driven outside a write");
    a_we_sel: assert property (@(posedge clk) disable iff (!rstn)
        !mem_we_n |-> !mem_cs_n && wr_q) // [R3]
        else $error("write strobe outside a write");
    a_oe_sel: assert property (@(posedge clk) disable iff (!rstn)
        !mem_oe_n |-> !mem_cs_n && !wr_q) // [R4]
        else $error("read strobe outside a read");
    a_cs_idle: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && state_q == EPM_HOLD |=> mem_cs_n) // [R5]
        else $error("select held after transfer");
    a_wait_len: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && state_q == EPM_SETUP && wait_states == EPM_WAIT_DEF ##1 clk_en [*3]
        |=> state_q == EPM_HOLD) // [R16]
        else $error("wait state count wrong");
    a_read_rsp: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && state_q == EPM_STROBE && wait_q == '0 && !wr_q
        |=> rsp_valid && rsp_rdata == $past(mem_data_in)) // [R1]
        else $error("read data not returned");
    a_hit_fast: assert property (@(posedge clk) disable iff (!rstn)
        take && hit |=> rsp_valid && mem_cs_n) // [R19]
        else $error("cache hit touched memory");

    c_read: cover property (@(posedge clk) disable iff (!rstn) !mem_oe_n ##1 rsp_valid);
    c_write: cover property (@(posedge clk) disable iff (!rstn) !mem_we_n);
    c_hit: cover property (@(posedge clk) disable iff (!rstn) take && hit);
endmodule

// ### epm_pkg.sv
// Constants shared by the external program memory port
package epm_pkg;
    localparam int EPM_ADDR_W = 21;
    localparam int EPM_DATA_W = 16;
    localparam int EPM_WAIT_W = 4;
    localparam logic [3:0] EPM_WAIT_DEF = 4'h2;
    localparam int EPM_RST_LAG = 2;
    localparam int EPM_CACHE_DEPTH = 64;
    localparam logic [20:0] EPM_ADDR_MAX = 21'h1fffff;

    typedef enum logic [1:0] {
        EPM_IDLE = 2'b00,
        EPM_SETUP = 2'b01,
        EPM_STROBE = 2'b11,
        EPM_HOLD = 2'b10
    } epm_state_t;
endpackage

// ### epm_reset_lag.sv
// Flash reset output lagging the hard reset
`timescale 1ns/1ns
module epm_reset_lag import epm_pkg::*; #(
    parameter int LAG = EPM_RST_LAG
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Reset out
    output logic memory_reset_n
);
    logic [LAG-1:0] shift_q;

    // Clock enable deliberately ignored: must release even if frozen
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shift_q <= '0; // [R6] [R7]
        end else begin
            shift_q <= {shift_q[LAG-2:0], 1'b1}; // [R6]
        end
    end

    assign memory_reset_n = shift_q[LAG-1];

    a_reset_lag: assert property (@(posedge clk) disable iff (!rstn)
        $rose(memory_reset_n) |-> $past(rstn, LAG)) // [R6]
        else $error("memory reset released too early");
    a_reset_static: assert property (@(posedge clk) disable iff (!rstn)
        memory_reset_n |=> memory_reset_n) // [R7]
        else $error("memory reset moved after boot");
endmodule

// ### epm_flash_model.sv
// Behavioural 16-bit word-mode flash on the far side of the memory pins
`timescale 1ns/1ns
module epm_flash_model (
    // Memory pins
    input wire logic [20:0] mem_addr,
    input wire logic [15:0] mem_data_out,
    input wire logic mem_we_n,
    input wire logic mem_oe_n,
    input wire logic mem_cs_n,
    input wire logic memory_reset_n,
    // Read data back to the port
    output logic [15:0] rdata
);
    // Sparse store so the full word space is available, erased cells read all ones
    logic [15:0] mem [int];
    logic [15:0] last_q = 16'h5a5a;
    logic drive;
    assign drive = !mem_oe_n && !mem_cs_n && memory_reset_n;
    // Programming only clears bits, so repeated programs of one word AND together
    // Commands, sector erase and timing are not modelled: one flat sector space
    always @(mem_we_n, mem_cs_n, mem_addr, mem_data_out) begin
        if (!mem_we_n && !mem_cs_n && memory_reset_n) begin
            mem[mem_addr] = (mem.exists(mem_addr) ? mem[mem_addr] : 16'hffff)
                & mem_data_out;
        end
    end
    always @(drive, mem_addr) begin
        if (drive) begin
            last_q = mem.exists(mem_addr) ? mem[mem_addr] : 16'hffff;
        end
    end
    // Released bus shows the inverse, never a stale word
    assign rdata = drive ? last_q : ~last_q;
endmodule

// ### external_program_memory_port_bench.sv
// Self-checking bench for the external program memory port
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
    $display("Error %0t got %h want %h", $time, a, b); end end
module external_program_memory_port_bench;
    import epm_pkg::*;
    logic clk = 0, rstn = 0, write_lock = 0, req_valid = 0, req_write = 0, req_fetch = 0;
    logic [3:0] wait_states = 4'h0;
    logic [20:0] req_addr = 21'h000000, mem_addr;
    logic [15:0] req_wdata = 16'h0000, rsp_rdata, mem_data_in, mem_data_out;
    logic req_ready, rsp_valid, mem_data_oe, mem_we_n, mem_oe_n, mem_cs_n, memory_reset_n;
    int failures = 0, n_compared = 0, cycles = 0;
    int w_list[3] = '{0, 2, 5};
    external_program_memory_port dut (.clk(clk), .rstn(rstn), .clk_en(1'b1),
        .wait_states(wait_states), .write_lock(write_lock), .req_valid(req_valid),
        .req_write(req_write), .req_fetch(req_fetch), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .mem_data_in(mem_data_in),
        .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_we_n(mem_we_n),
        .mem_oe_n(mem_oe_n), .mem_cs_n(mem_cs_n), .memory_reset_n(memory_reset_n));
    epm_flash_model flash (.mem_addr(mem_addr), .mem_data_out(mem_data_out),
        .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_cs_n(mem_cs_n),
        .memory_reset_n(memory_reset_n), .rdata(mem_data_in));
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // One request; counts cycles to the answer and chip-select low cycles
    task automatic xfer(logic w, logic f, logic [20:0] a, logic [15:0] d, int lat, int ncs,
            logic [15:0] exp);
        int j, cs;
        j = 0;
        cs = 0;
        while (req_ready !== 1'b1 && j < 50) begin
            @(negedge clk);
            j++;
        end
        req_valid = 1;
        req_write = w;
        req_fetch = f;
        req_addr = a;
        req_wdata = d;
        @(negedge clk);
        req_valid = 0;
        j = 0;
        while ((w ? req_ready : rsp_valid) !== 1'b1 && j < 40) begin
            cs += (mem_cs_n === 1'b0);
            @(negedge clk);
            j++;
        end
        `CHK(cs, ncs)
        if (!w) begin
            `CHK(j, lat)
            `CHK(rsp_rdata, exp)
        end
    endtask
    task automatic t_reset();
        repeat (8) @(negedge clk);
        `CHK({memory_reset_n, mem_cs_n, mem_we_n, mem_oe_n}, 4'h7)
        rstn = 1;
        @(negedge clk);
        `CHK(memory_reset_n, 1'b0)
        @(negedge clk);
        `CHK(memory_reset_n, 1'b1)
    endtask
    task automatic t_wait_states();
        int w;
        foreach (w_list[i]) begin
            w = w_list[i];
            wait_states = w[3:0];
            xfer(1, 0, 21'h000100 + w, 16'ha500 + w, 0, 3 + w, 16'h0000);
            xfer(0, 0, 21'h000100 + w, 0, 2 + w, 2 + w, 16'ha500 + w);
        end
    endtask
    task automatic t_edges();
        wait_states = EPM_WAIT_DEF;
        xfer(1, 0, EPM_ADDR_MAX, 16'hc3e1, 0, 5, 0);
        xfer(1, 0, 21'h000000, 16'h3c1e, 0, 5, 0);
        xfer(0, 0, EPM_ADDR_MAX, 0, 4, 4, 16'hc3e1);
        xfer(0, 0, 21'h000000, 0, 4, 4, 16'h3c1e);
    endtask
    task automatic t_lock();
        write_lock = 1;
        xfer(1, 0, 21'h000102, 16'h0bad, 0, 0, 0);
        write_lock = 0;
        xfer(0, 0, 21'h000102, 0, 4, 4, 16'ha502);
    endtask
    task automatic t_fetch();
        xfer(0, 1, 21'h003000, 0, 4, 4, 16'hffff);
        xfer(0, 1, 21'h003000, 0, 0, 0, 16'hffff);
        xfer(1, 0, 21'h003000, 16'h1234, 0, 5, 0);
        xfer(0, 1, 21'h003000, 0, 4, 4, 16'h1234);
        `CHK(memory_reset_n, 1'b1)
    endtask
    initial begin
        t_reset();
        t_wait_states();
        t_edges();
        t_lock();
        t_fetch();
        wrap_up();
    end
endmodule
